//--- rtl/dcb_top.v
// Discrete calculation blocks: iterative logic equation, inverter and bit-weighting program loader.
`timescale 1ns/100ps
`include "dcb_defs.vh"
module dcb_top #(
  parameter NPARAM   = 16,
  parameter IDXW     = 4,
  parameter PROF_W   = 16,
  parameter SCAN_CYC = `DCB_SCAN_CYC
) (
  input  wire              clk_sys,
  input  wire              rst,
  input  wire [NPARAM-1:0] disc_param,
  input  wire [15:0]       lg_src_mode,
  input  wire [8*IDXW-1:0] lg_src_idx,
  input  wire [1:0]        lg_rst_mode,
  input  wire [IDXW-1:0]   lg_rst_idx,
  input  wire [11:0]       eq_term_sel,
  input  wire [2:0]        eq_term_neg,
  input  wire [3:0]        eq_op,
  input  wire              eq_group,
  input  wire [1:0]        inv_src_mode,
  input  wire [IDXW-1:0]   inv_src_idx,
  input  wire [15:0]       bit_src_mode,
  input  wire [8*IDXW-1:0] bit_src_idx,
  input  wire [1:0]        en_src_mode,
  input  wire [IDXW-1:0]   en_src_idx,
  input  wire [7:0]        lim_low,
  input  wire [7:0]        lim_high,
  input  wire              lim_low_on,
  input  wire              lim_high_on,
  input  wire [1:0]        prog_sel_n,
  input  wire              store_wr,
  input  wire [6:0]        store_addr,
  input  wire [PROF_W-1:0] store_wdata,
  output reg               scan_tick_r,
  output reg               discrete_result_r,
  output reg               invert_result_r,
  output reg  [7:0]        numeric_result_r,
  output reg               limit_flash_r,
  output reg               prof_wr_r,
  output reg  [1:0]        prof_idx_r,
  output reg  [PROF_W-1:0] prof_data_r,
  output reg               load_busy_r,
  output reg               load_reject_r
);

  localparam ST_IDLE = 2'h0;
  localparam ST_READ = 2'h1;
  localparam ST_PUT  = 2'h2;

  // Selects a discrete source: off, a parameter, or a constant.
  function src_val;
    input [1:0]        mode;
    input [IDXW-1:0]   idx;
    input [NPARAM-1:0] prm;
    begin
      case (mode)
        `DCB_SRC_PARAM: src_val = prm[idx];
        `DCB_SRC_ONE:   src_val = 1'h1;
        default:        src_val = 1'h0;
      endcase
    end
  endfunction

  // Picks one equation operand and applies its NOT, which binds tighter than any operator.
  function term_val;
    input [3:0] sel;
    input       neg;
    input [7:0] ins;
    input       prior;
    reg         v;
    begin
      v = 1'h0;
      case (sel)
        `DCB_TERM_PRIOR: v = prior;
        `DCB_TERM_ZERO:  v = 1'h0;
        `DCB_TERM_ONE:   v = 1'h1;
        default:         v = (sel < 4'h8) ? ins[sel[2:0]] : 1'h0;
      endcase
      term_val = v ^ neg;
    end
  endfunction

  function apply_op;
    input [1:0] op;
    input       x;
    input       y;
    begin
      case (op)
        `DCB_OP_AND: apply_op = x & y;
        `DCB_OP_OR:  apply_op = x | y;
        `DCB_OP_XOR: apply_op = x ^ y;
        default:     apply_op = 1'h0;
      endcase
    end
  endfunction

  // Programs held for N programmers: 96/N.
  function [6:0] prog_count;
    input [1:0] nsel;
    begin
      case (nsel)
        2'h0:    prog_count = 7'h60;
        2'h1:    prog_count = 7'h30;
        2'h2:    prog_count = 7'h20;
        default: prog_count = 7'h18;
      endcase
    end
  endfunction

  // Scan divider: every calculation advances once per machine scan.
  reg [31:0] scan_cnt_r;
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      scan_cnt_r  <= 32'h0;
      scan_tick_r <= 1'h0;
    end else if (scan_cnt_r == SCAN_CYC - 1) begin
      scan_cnt_r  <= 32'h0;
      scan_tick_r <= 1'h1;
    end else begin
      scan_cnt_r  <= scan_cnt_r + 32'h1;
      scan_tick_r <= 1'h0;
    end
  end

  // Parameters come from other blocks' timing, so they are synchronised first.
  reg [NPARAM-1:0] prm_s1_r;
  reg [NPARAM-1:0] prm_s2_r;
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      prm_s1_r <= {NPARAM{1'h0}};
      prm_s2_r <= {NPARAM{1'h0}};
    end else begin
      prm_s1_r <= disc_param;
      prm_s2_r <= prm_s1_r;
    end
  end

  // Source resolution for the logic inputs and the weighted bits.
  reg [7:0] lg_in;
  reg [7:0] bcd_in;
  integer   i;
  always @* begin
    lg_in  = 8'h00;
    bcd_in = 8'h00;
    for (i = 0; i < 8; i = i + 1) begin
      lg_in[i]  = src_val(lg_src_mode[2*i +: 2], lg_src_idx[IDXW*i +: IDXW], prm_s2_r);
      bcd_in[i] = src_val(bit_src_mode[2*i +: 2], bit_src_idx[IDXW*i +: IDXW], prm_s2_r);
    end
  end

  wire lg_reset  = src_val(lg_rst_mode, lg_rst_idx, prm_s2_r);
  wire inv_in    = src_val(inv_src_mode, inv_src_idx, prm_s2_r);
  wire en_now    = src_val(en_src_mode, en_src_idx, prm_s2_r);

  // Three-operand equation. The prior term reads the output of the preceding scan.
  wire t0 = term_val(eq_term_sel[3:0],  eq_term_neg[0], lg_in, discrete_result_r);
  wire t1 = term_val(eq_term_sel[7:4],  eq_term_neg[1], lg_in, discrete_result_r);
  wire t2 = term_val(eq_term_sel[11:8], eq_term_neg[2], lg_in, discrete_result_r);
  wire [1:0] op0 = eq_op[1:0];
  wire [1:0] op1 = eq_op[3:2];

  // With grouping, (t0 op0 t1) op1 t2 is the iterative form (A OR B) AND prior.
  // Without it, AND binds before OR and XOR; equal operators go left to right.
  reg eq_val;
  always @* begin
    if (eq_group) begin
      eq_val = apply_op(op1, apply_op(op0, t0, t1), t2);
    end else if (op1 == `DCB_OP_AND && op0 != `DCB_OP_AND) begin
      eq_val = apply_op(op0, t0, t1 & t2);
    end else begin
      eq_val = apply_op(op1, apply_op(op0, t0, t1), t2);
    end
  end

  // Weighted integer with limit clamping.
  reg [7:0] num_nxt;
  reg       flash_nxt;
  always @* begin
    num_nxt   = bcd_in;
    flash_nxt = 1'h0;
    if (lim_low_on && bcd_in < lim_low) begin
      num_nxt   = lim_low;
      flash_nxt = 1'h1;
    end else if (lim_high_on && bcd_in > lim_high) begin
      num_nxt   = lim_high;
      flash_nxt = 1'h1;
    end
  end

  reg en_prev_r;
  reg load_go_r;
  reg [7:0] load_prog_r;

  // Per-scan results.
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      discrete_result_r <= `DCB_RST_BIT;
      invert_result_r   <= 1'h1;
      numeric_result_r  <= `DCB_RST_NUM;
      limit_flash_r     <= 1'h0;
      en_prev_r         <= 1'h0;
      load_go_r         <= 1'h0;
      load_prog_r       <= 8'h00;
    end else begin
      load_go_r <= 1'h0;
      if (scan_tick_r) begin
        if (lg_reset) begin
          discrete_result_r <= 1'h0;
        end else begin
          discrete_result_r <= eq_val;
        end
        invert_result_r  <= ~inv_in;
        numeric_result_r <= num_nxt;
        limit_flash_r    <= flash_nxt;
        en_prev_r        <= en_now;
        if (en_now && !en_prev_r) begin
          load_go_r   <= 1'h1;
          load_prog_r <= num_nxt;
        end
      end
    end
  end

  // Program loader. Each profile takes a read cycle and a put cycle.
  reg  [1:0] ld_st_r;
  reg  [1:0] ld_st_nxt;
  reg  [6:0] rd_addr_r;
  reg  [1:0] cnt_r;
  wire [1:0] nmax     = prog_sel_n;
  wire [6:0] nprog    = prog_count(prog_sel_n);
  wire       prog_ok  = (load_prog_r != 8'h00) && (load_prog_r <= {1'h0, nprog});
  wire [6:0] prog_m1  = load_prog_r[6:0] - 7'h1;
  wire [8:0] base_w   = prog_m1 * ({5'h0, nmax} + 7'h1);
  wire [PROF_W-1:0] rd_data;

  always @* begin
    ld_st_nxt = ld_st_r;
    case (ld_st_r)
      ST_IDLE: begin
        if (load_go_r && prog_ok) begin
          ld_st_nxt = ST_READ;
        end
      end
      ST_READ: begin
        ld_st_nxt = ST_PUT;
      end
      ST_PUT: begin
        ld_st_nxt = (cnt_r == nmax) ? ST_IDLE : ST_READ;
      end
      default: begin
        ld_st_nxt = ST_IDLE;
      end
    endcase
  end

  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ld_st_r       <= ST_IDLE;
      rd_addr_r     <= 7'h00;
      cnt_r         <= 2'h0;
      prof_wr_r     <= 1'h0;
      prof_idx_r    <= 2'h0;
      prof_data_r   <= {PROF_W{1'h0}};
      load_busy_r   <= 1'h0;
      load_reject_r <= 1'h0;
    end else begin
      ld_st_r       <= ld_st_nxt;
      prof_wr_r     <= 1'h0;
      load_reject_r <= load_go_r && !prog_ok;
      case (ld_st_r)
        ST_IDLE: begin
          cnt_r     <= 2'h0;
          rd_addr_r <= base_w[6:0];
          if (load_go_r && prog_ok) begin
            load_busy_r <= 1'h1;
          end
        end
        ST_PUT: begin
          prof_wr_r   <= 1'h1;
          prof_idx_r  <= cnt_r;
          prof_data_r <= rd_data;
          cnt_r       <= cnt_r + 2'h1;
          rd_addr_r   <= rd_addr_r + 7'h1;
          if (cnt_r == nmax) begin
            load_busy_r <= 1'h0;
          end
        end
        default: begin
          cnt_r <= cnt_r;
        end
      endcase
    end
  end

  // The read is issued in ST_READ so the registered data are ready in ST_PUT.
  dcb_store #(
    .DW    (PROF_W),
    .DEPTH (`DCB_SLOTS),
    .AW    (`DCB_SLOT_AW)
  ) u_store (
    .clk_sys (clk_sys),
    .wr_en   (store_wr),
    .wr_addr (store_addr),
    .wr_data (store_wdata),
    .rd_en   (ld_st_r == ST_READ),
    .rd_addr (rd_addr_r),
    .rd_data (rd_data)
  );

endmodule // dcb_top

//--- rtl/dcb_defs.vh
// Constants for the discrete calculation blocks: source modes, equation codes, storage and scan timing.
`ifndef DCB_DEFS_VH
`define DCB_DEFS_VH

// Discrete source modes shared by every selectable input.
`define DCB_SRC_OFF    2'h0
`define DCB_SRC_PARAM  2'h1
`define DCB_SRC_ZERO   2'h2
`define DCB_SRC_ONE    2'h3

// Equation operand codes: inputs A..H are 0..7.
`define DCB_TERM_PRIOR 4'h8
`define DCB_TERM_ZERO  4'h9
`define DCB_TERM_ONE   4'ha

// Equation operator codes.
`define DCB_OP_AND     2'h0
`define DCB_OP_OR      2'h1
`define DCB_OP_XOR     2'h2

// Program storage.
`define DCB_SLOTS      96
`define DCB_SLOT_AW    7

// Machine scan period.
`define DCB_CLK_MHZ    100
`define DCB_SCAN_MS    250
`define DCB_SCAN_CYC   (`DCB_SCAN_MS * 1000 * `DCB_CLK_MHZ)

// Reset values.
`define DCB_RST_BIT    1'h0
`define DCB_RST_NUM    8'h00

`endif

//--- rtl/dcb_store.v
// Program storage memory with registered read data.
`timescale 1ns/100ps
`include "dcb_defs.vh"
module dcb_store #(
  parameter DW    = 16,
  parameter DEPTH = `DCB_SLOTS,
  parameter AW    = `DCB_SLOT_AW
) (
  input  wire          clk_sys,
  input  wire          wr_en,
  input  wire [AW-1:0] wr_addr,
  input  wire [DW-1:0] wr_data,
  input  wire          rd_en,
  input  wire [AW-1:0] rd_addr,
  output reg  [DW-1:0] rd_data
);

  reg [DW-1:0] mem [0:DEPTH-1];

  // No reset on the array so it maps onto block memory.
  always @(posedge clk_sys) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    if (rd_en) begin
      rd_data <= mem[rd_addr];
    end
  end

endmodule // dcb_store

//--- dv/dcb_chk.sv
// Concurrent checks on the ports of the discrete calculation blocks.
`timescale 1ns/100ps
`include "dcb_defs.vh"
module dcb_chk (
  input wire       clk_sys,
  input wire       rst,
  input wire [1:0] lg_rst_mode,
  input wire [1:0] inv_src_mode,
  input wire [7:0] lim_low,
  input wire [7:0] lim_high,
  input wire       lim_low_on,
  input wire       lim_high_on,
  input wire [1:0] prog_sel_n,
  input wire       scan_tick_r,
  input wire       discrete_result_r,
  input wire       invert_result_r,
  input wire [7:0] numeric_result_r,
  input wire       limit_flash_r,
  input wire       prof_wr_r,
  input wire [1:0] prof_idx_r,
  input wire       load_busy_r,
  input wire       load_reject_r
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  property p_hold;
    !scan_tick_r |=> $stable({discrete_result_r, invert_result_r, numeric_result_r, limit_flash_r});
  endproperty
  a_hold: assert property (p_hold) else $error("output moved between scans");
  property p_rst;
    scan_tick_r && lg_rst_mode == `DCB_SRC_ONE |=> !discrete_result_r;
  endproperty
  a_rst: assert property (p_rst) else $error("logic reset ignored");
  property p_inv;
    scan_tick_r && inv_src_mode[1] |=> invert_result_r == !$past(inv_src_mode[0]);
  endproperty
  a_inv: assert property (p_inv) else $error("inverter wrong");
  property p_hi;
    scan_tick_r && lim_high_on |=> numeric_result_r <= $past(lim_high);
  endproperty
  a_hi: assert property (p_hi) else $error("high clamp missed");
  property p_lo;
    scan_tick_r && lim_low_on |=> numeric_result_r >= $past(lim_low);
  endproperty
  a_lo: assert property (p_lo) else $error("low clamp missed");
  property p_first;
    $rose(load_busy_r) |-> ##2 prof_wr_r && prof_idx_r == 2'h0;
  endproperty
  a_first: assert property (p_first) else $error("first profile write late");
  property p_last;
    $fell(load_busy_r) |-> prof_wr_r && prof_idx_r == prog_sel_n;
  endproperty
  a_last: assert property (p_last) else $error("load ended on wrong profile");
  property p_rej;
    load_reject_r |-> !prof_wr_r [*8];
  endproperty
  a_rej: assert property (p_rej) else $error("write after reject");
endmodule // dcb_chk
bind dcb_top dcb_chk u_chk (.*);

//--- dv/dcb_prof.sv
// Profile function block model that takes each profile write.
`timescale 1ns/100ps
module dcb_prof (
  input  wire        clk_sys,
  input  wire        prof_wr_r,
  input  wire [1:0]  prof_idx_r,
  input  wire [15:0] prof_data_r,
  output reg  [63:0] blk,
  output reg  [7:0]  wr_cnt
);
  initial begin
    blk = 64'h0;
    wr_cnt = 8'h00;
  end
  // The write count lets the bench catch stray or missing strobes.
  always @(posedge clk_sys) begin
    if (prof_wr_r) begin
      blk[16*prof_idx_r+:16] <= prof_data_r;
      wr_cnt <= wr_cnt + 8'h01;
    end
  end
endmodule // dcb_prof

//--- dv/discrete_calc_blocks_test.sv
// Self-checking bench for the discrete calculation blocks.
`timescale 1ns/100ps
module discrete_calc_blocks_test;
  reg         clk_sys = 0, rst = 1, grp = 1, lon = 0, hon = 0, we = 0;
  reg  [15:0] prm = 0, lgm = 0, bm = 0, sw = 0;
  reg  [11:0] sel = 0;
  reg  [3:0]  op = 0, ii = 4'h3;
  reg  [2:0]  neg = 0;
  reg  [1:0]  rm = 0, im = 0, em = 0, n = 0;
  reg  [7:0]  lo = 8'h0a, hi = 8'h14, c0;
  reg  [6:0]  wa = 0;
  wire        tick, dres, ires, flash, wr, busy, rej;
  wire [7:0]  num, wcnt;
  wire [1:0]  idx;
  wire [15:0] pd;
  wire [63:0] blk;
  integer     error_cnt = 0, total_checks = 0, rcnt = 0, i, wt;
  always #5 clk_sys = ~clk_sys;
  // Counted mid-cycle, where the one-cycle reject pulse has settled.
  always @(negedge clk_sys) if (rej === 1'b1) rcnt = rcnt + 1;
  dcb_top #(.SCAN_CYC(20)) u_dut (.clk_sys(clk_sys), .rst(rst), .disc_param(prm), .lg_src_mode(lgm),
    .lg_src_idx(32'h0), .lg_rst_mode(rm), .lg_rst_idx(4'h0), .eq_term_sel(sel), .eq_term_neg(neg),
    .eq_op(op), .eq_group(grp), .inv_src_mode(im), .inv_src_idx(ii), .bit_src_mode(bm),
    .bit_src_idx(32'h0), .en_src_mode(em), .en_src_idx(4'h0), .lim_low(lo), .lim_high(hi),
    .lim_low_on(lon), .lim_high_on(hon), .prog_sel_n(n), .store_wr(we), .store_addr(wa),
    .store_wdata(sw), .scan_tick_r(tick), .discrete_result_r(dres), .invert_result_r(ires),
    .numeric_result_r(num), .limit_flash_r(flash), .prof_wr_r(wr), .prof_idx_r(idx),
    .prof_data_r(pd), .load_busy_r(busy), .load_reject_r(rej));
  dcb_prof u_prof (.clk_sys(clk_sys), .prof_wr_r(wr), .prof_idx_r(idx), .prof_data_r(pd),
    .blk(blk), .wr_cnt(wcnt));
  task end_sim;
    begin
      $display("errors %0d checks %0d", error_cnt, total_checks);
      if (error_cnt == 0 && total_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
    end
  endtask
  task chk(input [15:0] got, input [15:0] exp);
    begin
      total_checks = total_checks + 1;
      if (got !== exp) begin
        error_cnt = error_cnt + 1;
        $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  // Constant sources for eight bits, so each scan sees a known pattern.
  function [15:0] cm(input [7:0] v);
    integer j;
    for (j = 0; j < 8; j = j + 1) cm[2*j+:2] = v[j] ? 2'h3 : 2'h2;
  endfunction
  // Returns just after the edge at which the design sampled the scan.
  // It keeps its own counter so that callers may loop on i around it.
  task scan;
    begin
      wt = 0;
      @(posedge clk_sys);
      while (tick !== 1'b1 && wt < 100) begin
        @(posedge clk_sys);
        wt = wt + 1;
      end
      if (wt >= 100) begin
        error_cnt = error_cnt + 1;
        $display("[ERR] %0t got %h exp %h", $time, 8'h00, 8'h01);
      end
      #1;
    end
  endtask
  task lg(input [7:0] v, input e);
    begin
      lgm = cm(v);
      scan;
      chk(dres, e);
    end
  endtask
  task t_logic;
    begin
      sel = 12'h980;
      op = 4'h5;
      lg(8'h01, 1);
      lg(8'h00, 1);
      rm = 2'h3;
      lg(8'h01, 0);
      rm = 2'h0;
      lg(8'h01, 1);
      sel = 12'h810;
      op = 4'h1;
      lg(8'h03, 1);
      lg(8'h01, 1);
      lg(8'h00, 0);
      lg(8'h01, 0);
      sel = 12'h210;
      lg(8'h01, 0);
      neg = 3'h4;
      lg(8'h01, 1);
      neg = 3'h0;
      grp = 0;
      lg(8'h01, 1);
    end
  endtask
  task t_inv;
    begin
      for (i = 0; i < 4; i = i + 1) begin
        im = i;
        prm = 16'h0008;
        scan;
        chk(ires, !im[0]);
      end
    end
  endtask
  task bits(input [7:0] v, input l, input h, input [7:0] e, input f);
    begin
      bm = cm(v);
      lon = l;
      hon = h;
      scan;
      chk(num, e);
      chk(flash, f);
    end
  endtask
  task ld(input [7:0] v, input [1:0] ns);
    begin
      n = ns;
      bm = cm(v);
      em = 2'h2;
      scan;
      c0 = wcnt;
      i = rcnt;
      em = 2'h3;
      scan;
      repeat (12) @(posedge clk_sys);
      #1;
      if (v >= 1 && v <= 96 / (ns + 1)) begin
        chk(wcnt - c0, ns + 1);
        for (i = 0; i <= ns; i = i + 1) chk(blk[16*i+:16], 16'h1000 + (v - 1) * (ns + 1) + i);
      end else begin
        chk(wcnt - c0, 0);
        chk(rcnt - i, 1);
      end
      c0 = wcnt;
      scan;
      chk(wcnt - c0, 0);
    end
  endtask
  initial begin
    #100000;
    error_cnt = error_cnt + 1;
    end_sim;
  end
  initial begin
    repeat (3) @(posedge clk_sys);
    #1 rst = 0;
    chk(ires, 1);
    chk(dres, 0);
    chk(num, 0);
    for (i = 0; i < 96; i = i + 1) begin
      we = 1;
      wa = i;
      sw = 16'h1000 + i;
      @(posedge clk_sys);
      #1;
    end
    we = 0;
    t_logic;
    t_inv;
    bits(8'h81, 0, 0, 8'h81, 0);
    bits(8'h05, 1, 1, 8'h0a, 1);
    bits(8'h1e, 1, 1, 8'h14, 1);
    bits(8'h14, 1, 1, 8'h14, 0);
    bits(8'h1e, 1, 0, 8'h1e, 0);
    // Bits 0 and 1 read parameter 0, the rest are off.
    prm = 16'h0001;
    bm = 16'h0005;
    lon = 0;
    hon = 0;
    scan;
    chk(num, 8'h03);
    chk(flash, 0);
    lon = 0;
    ld(8'h03, 2'h1);
    ld(8'h18, 2'h3);
    ld(8'h20, 2'h2);
    ld(8'h60, 2'h0);
    ld(8'h00, 2'h1);
    ld(8'h31, 2'h1);
    end_sim;
  end
endmodule // discrete_calc_blocks_test
